// [design/i2c_target_framing.v]
// I2C target: START/STOP detection, address match, byte framing, ACK,
// clock stretching. Written bytes pass a FIFO to the user side.
// Assumes SCL and SDA arrive as open-drain pins; oe low means drive low.
`include "i2c_target_defs.vh"
module i2c_target_framing (
    input  wire       core_clk,
    input  wire       rstn,
    input  wire       clk_en,
    input  wire [6:0] strap_addr,
    input  wire       scl_in,
    output reg        scl_out,
    output reg        scl_oe,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    output reg        bus_busy,
    output reg        addressed,
    output reg        read_mode,
    output reg  [7:0] rx_data,
    output reg        rx_valid,
    input  wire       rx_ready,
    input  wire [7:0] tx_data,
    input  wire       tx_valid,
    output reg        tx_ready
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection
    reg        scl_m;
    reg        scl_s;
    reg        scl_d;
    reg        sda_m;
    reg        sda_s;
    reg        sda_d;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_det;
    wire       stop_det;

    always @(posedge core_clk) begin
        if (!rstn) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else if (clk_en) begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    assign scl_rise  = scl_s && !scl_d;
    assign scl_fall  = !scl_s && scl_d;
    assign start_det = scl_s && scl_d && sda_d && !sda_s;
    assign stop_det  = scl_s && scl_d && !sda_d && sda_s;

    ////////////////////////////////////////////////////////////////////////
    // Receive FIFO toward the user side
    reg        fifo_push;
    reg  [7:0] fifo_in;
    wire       fifo_in_ready;
    wire [7:0] fifo_out;
    wire       fifo_out_valid;
    wire       fifo_pop;

    assign fifo_pop = fifo_out_valid && (!rx_valid || rx_ready);

    i2c_byte_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH),
        .PTR_W (`FIFO_PTR_W)
    ) u_fifo (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .clk_en    (clk_en),
        .in_data   (fifo_in),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop)
    );

    ////////////////////////////////////////////////////////////////////////
    // Byte framing state machine
    reg [2:0]            state;
    reg [3:0]            bit_cnt;
    reg [7:0]            shift;
    reg [7:0]            tx_shift;
    reg                  host_nack;
    reg                  stretch;

    always @(posedge core_clk) begin
        if (!rstn) begin
            state     <= `ST_IDLE;
            bit_cnt   <= 4'h0;
            shift     <= 8'h00;
            tx_shift  <= 8'hFF;
            host_nack <= 1'b0;
            stretch   <= 1'b0;
            bus_busy  <= 1'b0;
            addressed <= 1'b0;
            read_mode <= 1'b0;
            sda_out   <= 1'b0;
            sda_oe    <= 1'b1;
            scl_out   <= 1'b0;
            scl_oe    <= 1'b1;
            fifo_push <= 1'b0;
            fifo_in   <= 8'h00;
            tx_ready  <= 1'b0;
            rx_data   <= 8'h00;
            rx_valid  <= 1'b0;
        end else if (clk_en) begin
            fifo_push <= 1'b0;
            tx_ready  <= 1'b0;
            if (fifo_pop) begin
                rx_data  <= fifo_out;
                rx_valid <= 1'b1;
            end else if (rx_ready) begin
                rx_valid <= 1'b0;
            end
            if (start_det) begin
                bus_busy  <= 1'b1;
                state     <= `ST_ADDR;
                bit_cnt   <= 4'h0;
                addressed <= 1'b0;
                sda_oe    <= 1'b1;
                scl_oe    <= 1'b1;
                stretch   <= 1'b0;
            end else if (stop_det) begin
                bus_busy  <= 1'b0;
                state     <= `ST_IDLE;
                addressed <= 1'b0;
                sda_oe    <= 1'b1;
                scl_oe    <= 1'b1;
                stretch   <= 1'b0;
            end else begin
                // Stretch SCL low while no room or no byte to send
                if (stretch) begin
                    if (state == `ST_WR_DATA && fifo_in_ready) begin
                        stretch <= 1'b0;
                        scl_oe  <= 1'b1;
                    end else if (state == `ST_RD_DATA && tx_ready) begin
                        // Data bit settles a cycle before SCL is let go
                        stretch <= 1'b0;
                        scl_oe  <= 1'b1;
                    end else if (state == `ST_RD_DATA && tx_valid) begin
                        tx_shift <= {tx_data[6:0], 1'b1};
                        tx_ready <= 1'b1;
                        sda_oe   <= tx_data[7];
                    end
                end
                case (state)
                `ST_IDLE: begin
                    sda_oe <= 1'b1;
                end
                `ST_ADDR, `ST_WR_DATA: begin
                    if (scl_rise) begin
                        shift   <= {shift[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (scl_fall && bit_cnt == `ACK_SLOT) begin
                        bit_cnt <= 4'h0;
                        if (state == `ST_ADDR) begin
                            if (shift[7:1] == strap_addr) begin
                                addressed <= 1'b1;
                                read_mode <= shift[0];
                                sda_oe    <= 1'b0;
                                state     <= `ST_ADDR_ACK;
                            end else begin
                                state <= `ST_IGNORE;
                            end
                        end else begin
                            fifo_in   <= shift;
                            fifo_push <= 1'b1;
                            sda_oe    <= 1'b0;
                            state     <= `ST_WR_ACK;
                        end
                    end
                end
                `ST_ADDR_ACK, `ST_WR_ACK: begin
                    if (scl_fall) begin
                        sda_oe <= 1'b1;
                        if (read_mode) begin
                            state   <= `ST_RD_DATA;
                            stretch <= 1'b1;
                            scl_oe  <= 1'b0;
                        end else begin
                            state   <= `ST_WR_DATA;
                            if (!fifo_in_ready) begin
                                stretch <= 1'b1;
                                scl_oe  <= 1'b0;
                            end
                        end
                    end
                end
                `ST_RD_DATA: begin
                    if (scl_rise && !stretch)
                        bit_cnt <= bit_cnt + 4'h1;
                    if (scl_fall && !stretch) begin
                        if (bit_cnt == `ACK_SLOT) begin
                            sda_oe <= 1'b1;
                            state  <= `ST_RD_ACK;
                        end else begin
                            sda_oe   <= tx_shift[7];
                            tx_shift <= {tx_shift[6:0], 1'b1};
                        end
                    end
                end
                `ST_RD_ACK: begin
                    if (scl_rise)
                        host_nack <= sda_s;
                    if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        if (host_nack) begin
                            state <= `ST_IGNORE;
                        end else begin
                            state   <= `ST_RD_DATA;
                            stretch <= 1'b1;
                            scl_oe  <= 1'b0;
                        end
                    end
                end
                default: begin
                    sda_oe <= 1'b1;
                end
                endcase
            end
        end
    end
endmodule

// [design/i2c_target_defs.vh]
// Constants for the I2C target byte framing block.
// Assumes inclusion by bare name from the design files.
`ifndef I2C_TARGET_DEFS_VH
`define I2C_TARGET_DEFS_VH
`define ADDR_BITS       7
`define DATA_BITS       8
`define BIT_CNT_W       4
`define ACK_SLOT        4'h8
`define FIFO_WIDTH      8
`define FIFO_DEPTH      16
`define FIFO_PTR_W      4
`define ST_IDLE         3'h0
`define ST_ADDR         3'h1
`define ST_ADDR_ACK     3'h2
`define ST_WR_DATA      3'h3
`define ST_WR_ACK       3'h4
`define ST_RD_DATA      3'h5
`define ST_RD_ACK       3'h6
`define ST_IGNORE       3'h7
`endif

// [design/i2c_byte_fifo.v]
// Byte FIFO with valid/ready on both sides.
// Assumes one clock, synchronous active-low reset and clock enable.
module i2c_byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter PTR_W = 4
) (
    input  wire             core_clk,
    input  wire             rstn,
    input  wire             clk_en,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [PTR_W:0]   wr_ptr;
    reg [PTR_W:0]   rd_ptr;
    wire            full;
    wire            empty;

    assign full  = (wr_ptr[PTR_W] != rd_ptr[PTR_W]) &&
                   (wr_ptr[PTR_W-1:0] == rd_ptr[PTR_W-1:0]);
    assign empty = (wr_ptr == rd_ptr);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr[PTR_W-1:0]];

    always @(posedge core_clk) begin
        if (!rstn) begin
            wr_ptr <= {(PTR_W+1){1'b0}};
            rd_ptr <= {(PTR_W+1){1'b0}};
        end else if (clk_en) begin
            if (in_valid && !full) begin
                mem[wr_ptr[PTR_W-1:0]] <= in_data;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (out_ready && !empty)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

// [test/i2c_target_framing_chk.sv]
// Checker for the I2C target framing block's pin and stream behaviour.
// Assumes it is bound to the top module, one clock, reset active low.
module i2c_target_framing_chk (
    input logic       core_clk,
    input logic       rstn,
    input logic       scl_in,
    input logic       sda_in,
    input logic       scl_oe,
    input logic       sda_oe,
    input logic       bus_busy,
    input logic       addressed,
    input logic       read_mode,
    input logic [7:0] rx_data,
    input logic       rx_valid,
    input logic       rx_ready,
    input logic       tx_valid,
    input logic       tx_ready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_start;
        scl_in && $fell(sda_in);
    endsequence
    sequence s_stop;
        scl_in && $rose(sda_in);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_busy_on_start: assert property (s_start |-> ##[1:5] bus_busy)
        else $error("busy missed after start");
    a_free_on_stop: assert property (s_stop |-> ##[1:5] !bus_busy)
        else $error("busy held after stop");
    a_sda_chg_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data drive changed with clock high");
    a_drive_in_busy: assert property (!sda_oe |-> bus_busy)
        else $error("data driven outside a transfer");
    a_stretch_own: assert property (!scl_oe |-> addressed)
        else $error("clock held while not addressed");
    a_read_stretch: assert property (
        !scl_oe && read_mode && !tx_valid |=> !scl_oe)
        else $error("read stretch ended without data");
    a_ack_own_addr: assert property (
        $fell(sda_oe) |-> addressed)
        else $error("data pulled low without a match");
    a_dir_stable: assert property (
        addressed && $past(addressed) |-> $stable(read_mode))
        else $error("direction changed within a transfer");
    a_tx_pulse: assert property (
        tx_ready |-> addressed && read_mode ##1 !tx_ready)
        else $error("bad transmit take");
    a_rx_hold: assert property (
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("received byte dropped");
endmodule
bind i2c_target_framing i2c_target_framing_chk u_chk (
    .core_clk(core_clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
    .scl_oe(scl_oe), .sda_oe(sda_oe), .bus_busy(bus_busy),
    .addressed(addressed), .read_mode(read_mode), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_ready(tx_ready)
);

// [test/i2c_host_model.sv]
// Host bus model: makes the clock and frames transfers, open-drain.
// Assumes the bench ANDs its outputs with the target's onto the wires.
module i2c_host_model (
    input  logic scl,
    input  logic sda,
    output logic scl_drv,
    output logic sda_drv
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    // One clock pulse of 200 ns, longer while the target holds it
    task automatic bit_xfer(input logic b, output logic r);
        #50 sda_drv = b;
        #50 scl_drv = 1'b1;
        wait (scl === 1'b1);
        #1;
        #100 r = sda;
        scl_drv = 1'b0;
    endtask
    task automatic start;
        #50 sda_drv = 1'b1;
        #50 scl_drv = 1'b1;
        wait (scl === 1'b1);
        #1;
        #50 sda_drv = 1'b0;
        #100 scl_drv = 1'b0;
    endtask
    task automatic stop;
        #50 sda_drv = 1'b0;
        #50 scl_drv = 1'b1;
        wait (scl === 1'b1);
        #1;
        #50 sda_drv = 1'b1;
        #100;
    endtask
    task automatic xfer_byte(input logic [7:0] d, input logic a,
                             output logic [7:0] q, output logic k);
        for (int i = 7; i >= 0; i--)
            bit_xfer(d[i], q[i]);
        bit_xfer(a, k);
    endtask
endmodule

// [test/i2c_target_framing_test.sv]
// Self-checking bench for the I2C target framing block.
// Assumes the host model as bus partner and pull-ups on both lines.
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin \
    n_errors++; $display("[ERR] %s exp %h got %h", nm, e, a); end end
module i2c_target_framing_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [6:0]  strap_addr = 7'h4A;
    logic        rx_ready = 1'b0;
    logic [7:0]  tx_data = 8'h00;
    logic        tx_valid = 1'b0;
    logic        stretched = 1'b0;
    logic [31:0] seed = 32'h8C6F;
    logic [31:0] rnd = 32'h8C6F;
    logic        ack;
    logic [7:0]  tx_q[$];
    logic [7:0]  rx_got[$];
    logic [7:0]  sent[$];
    int          n_errors = 0;
    int          cmp_count = 0;
    wire         scl_h, sda_h, scl_oe, scl_out, sda_oe, sda_out;
    wire         rx_valid, tx_ready, bus_busy, addressed, read_mode;
    wire [7:0]   rx_data;
    wire         scl = scl_h & (scl_oe | scl_out);
    wire         sda = sda_h & (sda_oe | sda_out);
    i2c_target_framing DUT (.core_clk(core_clk), .rstn(rstn), .clk_en(1'b1),
        .strap_addr(strap_addr), .scl_in(scl), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .bus_busy(bus_busy), .addressed(addressed), .read_mode(read_mode),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
    i2c_host_model host (.scl(scl), .sda(sda), .scl_drv(scl_h),
        .sda_drv(sda_h));
    always #12.5 core_clk = ~core_clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function logic exp_ack(input logic [7:0] a);
        return (a[7:1] == strap_addr) ? 1'b0 : 1'b1;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // User side: drain stalls until the first write stretch is seen
    always @(posedge core_clk) begin
        seed <= xs(seed);
        rx_ready <= stretched & (seed[1:0] == 2'h0);
        if (rstn && !scl_oe && !read_mode) stretched <= 1'b1;
        if (rx_valid && rx_ready) rx_got.push_back(rx_data);
        if (tx_ready) void'(tx_q.pop_front());
        tx_valid <= (tx_q.size() != 0);
        tx_data <= (tx_q.size() != 0) ? tx_q[0] : 8'h00;
    end
    task automatic trans(input logic [7:0] a, input int n);
        logic [7:0] d;
        logic [7:0] rdq[$];
        for (int i = 0; i < n && a[0]; i++) begin
            rnd = xs(rnd);
            rdq.push_back(rnd[7:0]);
            tx_q.push_back(rnd[7:0]);
        end
        host.start();
        host.xfer_byte(a, 1'b1, d, ack);
        `CHK("addr ack", exp_ack(a), ack)
        `CHK("busy", 1'b1, bus_busy)
        `CHK("match", !exp_ack(a), addressed)
        if (!exp_ack(a)) `CHK("dir", a[0], read_mode)
        for (int i = 0; i < n; i++) begin
            rnd = xs(rnd);
            if (!a[0] && !exp_ack(a)) sent.push_back(rnd[7:0]);
            if (a[0]) host.xfer_byte(8'hFF, i == n - 1, d, ack);
            else host.xfer_byte(rnd[7:0], 1'b1, d, ack);
            if (a[0]) `CHK("rd byte", rdq.pop_front(), d)
            else `CHK("wr ack", exp_ack(a), ack)
        end
        host.stop();
        #300;
        `CHK("free", 1'b0, bus_busy)
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        `CHK("sda idle", 1'b1, sda_oe)
        `CHK("scl idle", 1'b1, scl_oe)
        `CHK("idle", 1'b0, bus_busy)
        trans({strap_addr, 1'b0}, 20);
        trans({strap_addr ^ 7'h40, 1'b0}, 1);
        trans({strap_addr, 1'b1}, 3);
        repeat (6) begin
            rnd = xs(rnd);
            trans({strap_addr, rnd[8]}, 1 + rnd[1:0]);
        end
        repeat (2000) if (rx_got.size() < sent.size()) @(posedge core_clk);
        `CHK("rx count", sent.size(), rx_got.size())
        foreach (sent[i]) `CHK("rx byte", sent[i], rx_got[i])
        `CHK("stretch", 1'b1, stretched)
        test_done();
    end
endmodule
